// ---- rtl/arc_zone_pkg.sv ----
package arc_zone_pkg;
  // Register byte offsets on the plain register port.
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_ZLIGHT = 5'h04;
  localparam logic [4:0] ADDR_PH_LIM = 5'h08;
  localparam logic [4:0] ADDR_RES_LIM = 5'h0c;
  localparam logic [4:0] ADDR_SENS_CFG = 5'h10;
  localparam logic [4:0] ADDR_SAMP_REQ = 5'h14;
  localparam logic [4:0] ADDR_STATUS = 5'h18;
  // Control register fields.
  localparam int CTRL_ZEN_LSB = 0;
  localparam int CTRL_PHEN_LSB = 4;
  localparam int CTRL_RESEN_LSB = 8;
  localparam int CTRL_RSEL_LSB = 12;
  localparam int CTRL_PSUP_BIT = 14;
  // Residual input selection codes.
  localparam logic [1:0] RSEL_NONE = 2'h0;
  localparam logic [1:0] RSEL_A = 2'h1;
  localparam logic [1:0] RSEL_B = 2'h2;
  // Sensor configuration fields.
  localparam int SCFG_UNITS_LSB = 8;
  // Status register fields.
  localparam int ST_LIGHT_LSB = 0;
  localparam int ST_BI = 4;
  localparam int ST_PHS = 5;
  localparam int ST_RSS = 6;
  localparam int ST_PHB = 7;
  localparam int ST_RSB = 8;
  localparam int ST_TRIP_LSB = 9;
  localparam int ST_ZBLK_LSB = 13;
  localparam int ST_SFLT_LSB = 17;
  localparam int ST_IOF = 21;
  localparam int ST_W = 22;
  // Reset values; limits are in thousandths of nominal current.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] ZLIGHT_RST = 16'h0000;
  localparam logic [15:0] LIM_RST = 16'h04b0;
  localparam logic [10:0] SCFG_RST = 11'h000;
  localparam logic [3:0] SAMP_REQ_RST = 4'h1;
  localparam logic [3:0] SAMP_CNT_MAX = 4'hf;
  // Timing: samples arrive on a 5 ms base; test pulses are masked for 200 us.
  localparam int SAMPLE_BASE_MS = 5;
  localparam int CLK_MHZ = 10;
  localparam int PSUP_TIME_US = 200;
  localparam logic [10:0] PSUP_CYCLES = 11'(PSUP_TIME_US * CLK_MHZ);
endpackage

// ---- rtl/arc_zone_trip_logic.sv ----
// Behaviour
// - Four light channels, three sensors each.
// - Channel light output follows any sensor.
// - Binary input output follows energized input.
// - Current starts when sample exceeds limit.
// - Blocked current asserts blocked output instead.
// - Zone trips on light and enabled currents.
// - Blocked zone asserts blocked, not trip.
// - Channel sensor count mismatch raises fault.
// - Remote unit count mismatch raises fault.
// - Enabled current required with light.
// - Current needs required count of samples.
// - Three phase, two residual samples taken.
// - Phase, residual or both by configuration.
// - Per-zone channel light enables, ORed together.
// - Pressure channels treated as light channels.
// - Test pulses masked from binary input.
// - Disabled zone never trips or blocks.
// - Separate phase and residual zone enables.
// - Residual input select: none, first, second.
// - Configured sensor count zero to three.
`timescale 1ns/10ps
`default_nettype none
module arc_zone_trip_logic (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [3:0] sensor_light,
  input wire logic [7:0] sensor_detected,
  input wire logic [2:0] units_detected,
  input wire logic arc_binary_input,
  input wire logic sample_tick,
  input wire logic [15:0] phase_current_a,
  input wire logic [15:0] phase_current_b,
  input wire logic [15:0] phase_current_c,
  input wire logic [15:0] residual_input_a,
  input wire logic [15:0] residual_input_b,
  input wire logic phase_block,
  input wire logic residual_block,
  input wire logic [3:0] zone_block,
  output logic [3:0] light_out,
  output logic binary_out,
  output logic phase_start,
  output logic phase_blocked,
  output logic residual_start,
  output logic residual_blocked,
  output logic [3:0] zone_trip,
  output logic [3:0] zone_blocked,
  output logic [3:0] sensor_fault,
  output logic io_unit_fault
);

  logic [31:0] ctrl_r;
  logic [15:0] zlight_r;
  logic [15:0] ph_lim_r;
  logic [15:0] res_lim_r;
  logic [10:0] scfg_r;
  logic [3:0] samp_req_r;
  logic [31:0] rdata_r;
  logic [15:0] sync1_r;
  logic [15:0] sync2_r;
  logic [15:0] sync3_r;
  logic [15:0] pin_r;
  logic [3:0] ph_cnt_r;
  logic [3:0] res_cnt_r;
  logic [10:0] bi_cnt_r;
  logic [arc_zone_pkg::ST_W-1:0] stat_r;
  logic [arc_zone_pkg::ST_W-1:0] stat_nxt;

  // Register decode and read selection.
  wire wr_ctrl = reg_wr && (reg_addr == arc_zone_pkg::ADDR_CTRL);
  wire wr_zlight = reg_wr && (reg_addr == arc_zone_pkg::ADDR_ZLIGHT);
  wire wr_ph_lim = reg_wr && (reg_addr == arc_zone_pkg::ADDR_PH_LIM);
  wire wr_res_lim = reg_wr && (reg_addr == arc_zone_pkg::ADDR_RES_LIM);
  wire wr_scfg = reg_wr && (reg_addr == arc_zone_pkg::ADDR_SENS_CFG);
  wire wr_samp = reg_wr && (reg_addr == arc_zone_pkg::ADDR_SAMP_REQ);
  wire [31:0] rd_sel =
    (reg_addr == arc_zone_pkg::ADDR_CTRL) ? ctrl_r :
    (reg_addr == arc_zone_pkg::ADDR_ZLIGHT) ? {16'h0000, zlight_r} :
    (reg_addr == arc_zone_pkg::ADDR_PH_LIM) ? {16'h0000, ph_lim_r} :
    (reg_addr == arc_zone_pkg::ADDR_RES_LIM) ? {16'h0000, res_lim_r} :
    (reg_addr == arc_zone_pkg::ADDR_SENS_CFG) ? {21'h0, scfg_r} :
    (reg_addr == arc_zone_pkg::ADDR_SAMP_REQ) ? {28'h0000000, samp_req_r} :
    (reg_addr == arc_zone_pkg::ADDR_STATUS) ? {10'h0, stat_r} :
    32'h0000_0000;

  // Control fields.
  wire [3:0] zone_en = ctrl_r[arc_zone_pkg::CTRL_ZEN_LSB +: 4];
  wire [3:0] zone_ph_en = ctrl_r[arc_zone_pkg::CTRL_PHEN_LSB +: 4];
  wire [3:0] zone_res_en = ctrl_r[arc_zone_pkg::CTRL_RESEN_LSB +: 4];
  wire [1:0] res_sel = ctrl_r[arc_zone_pkg::CTRL_RSEL_LSB +: 2];
  wire pulse_sup = ctrl_r[arc_zone_pkg::CTRL_PSUP_BIT];
  wire [7:0] sens_cfg = scfg_r[7:0];
  wire [2:0] units_cfg = scfg_r[arc_zone_pkg::SCFG_UNITS_LSB +: 3];

  // Register file; full words only, reserved bits are dropped on write.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_r <= arc_zone_pkg::CTRL_RST;
      zlight_r <= arc_zone_pkg::ZLIGHT_RST;
      ph_lim_r <= arc_zone_pkg::LIM_RST;
      res_lim_r <= arc_zone_pkg::LIM_RST;
      scfg_r <= arc_zone_pkg::SCFG_RST;
      samp_req_r <= arc_zone_pkg::SAMP_REQ_RST;
    end
    else if (clk_en)
    begin
      if (wr_ctrl)
        ctrl_r <= {17'h0, reg_wdata[14:0]};
      if (wr_zlight)
        zlight_r <= reg_wdata[15:0];
      if (wr_ph_lim)
        ph_lim_r <= reg_wdata[15:0];
      if (wr_res_lim)
        res_lim_r <= reg_wdata[15:0];
      if (wr_scfg)
        scfg_r <= reg_wdata[10:0];
      if (wr_samp)
        samp_req_r <= reg_wdata[3:0];
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_r <= 32'h0000_0000;
    else if (clk_en)
      rdata_r <= reg_rd ? rd_sel : 32'h0000_0000;
  end
  assign reg_rdata = rdata_r;

  // Pin synchroniser; a bit changes once stages two and three agree.
  wire [15:0] pins_raw = {units_detected, sensor_detected, arc_binary_input, sensor_light};
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
      sync3_r <= 16'h0000;
      pin_r <= 16'h0000;
    end
    else if (clk_en)
    begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pin_r <= (sync2_r & sync3_r) | (pin_r & (sync2_r | sync3_r));
    end
  end

  // Four channels, each OR of its sensors at the pin.
  wire [3:0] light_f = pin_r[3:0];
  wire bi_f = pin_r[4];
  wire [7:0] det_f = pin_r[12:5];
  wire [2:0] units_f = pin_r[15:13];

  wire ph_over = (phase_current_a > ph_lim_r) || (phase_current_b > ph_lim_r) ||
                 (phase_current_c > ph_lim_r);
  wire [15:0] res_sample = (res_sel == arc_zone_pkg::RSEL_A) ? residual_input_a :
                           (res_sel == arc_zone_pkg::RSEL_B) ? residual_input_b : 16'h0000;
  wire res_over = (res_sel != arc_zone_pkg::RSEL_NONE) && (res_sample > res_lim_r);
  wire [3:0] req_eff = (samp_req_r == 4'h0) ? 4'h1 : samp_req_r;
  wire ph_qual = ph_cnt_r >= req_eff;
  wire res_qual = res_cnt_r >= req_eff;

  // Count consecutive samples over the limit.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ph_cnt_r <= 4'h0;
      res_cnt_r <= 4'h0;
    end
    else if (clk_en && sample_tick)
    begin
      if (!ph_over)
        ph_cnt_r <= 4'h0;
      else if (ph_cnt_r != arc_zone_pkg::SAMP_CNT_MAX)
        ph_cnt_r <= ph_cnt_r + 4'h1;
      if (!res_over)
        res_cnt_r <= 4'h0;
      else if (res_cnt_r != arc_zone_pkg::SAMP_CNT_MAX)
        res_cnt_r <= res_cnt_r + 4'h1;
    end
  end

  // Time how long the binary input has been high.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      bi_cnt_r <= 11'h000;
    else if (clk_en)
    begin
      if (!bi_f)
        bi_cnt_r <= 11'h000;
      else if (bi_cnt_r != arc_zone_pkg::PSUP_CYCLES)
        bi_cnt_r <= bi_cnt_r + 11'h001;
    end
  end
  wire bi_long = bi_cnt_r == arc_zone_pkg::PSUP_CYCLES;

  // Binary input passes, or only once longer than a test pulse.
  wire bi_eff = bi_f && (!pulse_sup || bi_long);

  // Current start unless the measurement is blocked.
  wire phs = ph_qual && !phase_block;
  wire rss = res_qual && !residual_block;
  // Blocked current shows on its blocked output.
  wire phb = ph_qual && phase_block;
  wire rsb = res_qual && residual_block;

  // Zone conditions, one per zone.
  logic [3:0] zone_light;
  logic [3:0] zone_cond;
  genvar z;
  generate
    for (z = 0; z < 4; z = z + 1)
    begin : g_zone
      // Any enabled channel lights the zone.
      // Pressure channels enter the same enable.
      assign zone_light[z] = |(zlight_r[4*z +: 4] & light_f);
      // Phase and residual enables per zone.
      // Either, both or no current used.
      assign zone_cond[z] = zone_en[z] && zone_light[z] &&
                            (!zone_ph_en[z] || phs) && (!zone_res_en[z] || rss);
    end
  endgenerate

  wire [3:0] trip_c = zone_cond & ~zone_block;
  wire [3:0] zblk_c = zone_cond & zone_block;

  wire [3:0] sflt_c;
  generate
    for (z = 0; z < 4; z = z + 1)
    begin : g_sens
      assign sflt_c[z] = det_f[2*z +: 2] != sens_cfg[2*z +: 2];
    end
  endgenerate
  wire iof_c = units_f != units_cfg;

  // Next status word.
  always_comb
  begin
    stat_nxt = '0;
    stat_nxt[arc_zone_pkg::ST_LIGHT_LSB +: 4] = light_f;
    stat_nxt[arc_zone_pkg::ST_BI] = bi_eff;
    stat_nxt[arc_zone_pkg::ST_PHS] = phs;
    stat_nxt[arc_zone_pkg::ST_RSS] = rss;
    stat_nxt[arc_zone_pkg::ST_PHB] = phb;
    stat_nxt[arc_zone_pkg::ST_RSB] = rsb;
    stat_nxt[arc_zone_pkg::ST_TRIP_LSB +: 4] = trip_c;
    stat_nxt[arc_zone_pkg::ST_ZBLK_LSB +: 4] = zblk_c;
    stat_nxt[arc_zone_pkg::ST_SFLT_LSB +: 4] = sflt_c;
    stat_nxt[arc_zone_pkg::ST_IOF] = iof_c;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      stat_r <= '0;
    else if (clk_en)
      stat_r <= stat_nxt;
  end

  // Output slices of the status word.
  assign light_out = stat_r[arc_zone_pkg::ST_LIGHT_LSB +: 4];
  assign binary_out = stat_r[arc_zone_pkg::ST_BI];
  assign phase_start = stat_r[arc_zone_pkg::ST_PHS];
  assign residual_start = stat_r[arc_zone_pkg::ST_RSS];
  assign phase_blocked = stat_r[arc_zone_pkg::ST_PHB];
  assign residual_blocked = stat_r[arc_zone_pkg::ST_RSB];
  assign zone_trip = stat_r[arc_zone_pkg::ST_TRIP_LSB +: 4];
  assign zone_blocked = stat_r[arc_zone_pkg::ST_ZBLK_LSB +: 4];
  assign sensor_fault = stat_r[arc_zone_pkg::ST_SFLT_LSB +: 4];
  assign io_unit_fault = stat_r[arc_zone_pkg::ST_IOF];

  // Checks on the decision outputs and the read data.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  property p_light;
    $past(clk_en) |-> light_out == $past(light_f);
  endproperty
  a_light: assert property (p_light) else $error("light output wrong");

  property p_bi;
    $past(clk_en) && !$past(pulse_sup) |-> binary_out == $past(bi_f);
  endproperty
  a_bi: assert property (p_bi) else $error("binary output wrong");

  property p_pulse;
    $past(clk_en) && $past(pulse_sup) && binary_out |-> $past(bi_cnt_r) == arc_zone_pkg::PSUP_CYCLES;
  endproperty
  a_pulse: assert property (p_pulse) else $error("test pulse passed");

  property p_cur_excl;
    !(phase_start && phase_blocked) && !(residual_start && residual_blocked);
  endproperty
  a_cur_excl: assert property (p_cur_excl) else $error("start and blocked");

  property p_qual;
    $past(clk_en) && ($past(ph_cnt_r) < $past(req_eff)) |-> !phase_start && !phase_blocked;
  endproperty
  a_qual: assert property (p_qual) else $error("phase start too early");

  property p_zone_off;
    $past(clk_en) |-> ((zone_trip | zone_blocked) & ~$past(zone_en)) == 4'h0;
  endproperty
  a_zone_off: assert property (p_zone_off) else $error("disabled zone active");

  property p_zone_excl;
    (zone_trip & zone_blocked) == 4'h0;
  endproperty
  a_zone_excl: assert property (p_zone_excl) else $error("trip and blocked");

  property p_trip_cur;
    $past(clk_en) && ((zone_trip & $past(zone_ph_en)) != 4'h0) |-> $past(phs);
  endproperty
  a_trip_cur: assert property (p_trip_cur) else $error("trip without current");

  property p_trip_light;
    $past(clk_en) |-> (zone_trip & ~$past(zone_light)) == 4'h0;
  endproperty
  a_trip_light: assert property (p_trip_light) else $error("trip without light");

  property p_sfault;
    $past(clk_en) |-> sensor_fault[0] == ($past(det_f[1:0]) != $past(sens_cfg[1:0]));
  endproperty
  a_sfault: assert property (p_sfault) else $error("sensor fault wrong");

  property p_iof;
    $past(clk_en) |-> io_unit_fault == ($past(units_f) != $past(units_cfg));
  endproperty
  a_iof: assert property (p_iof) else $error("unit fault wrong");

  property p_rd_idle;
    $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");

  c_trip: cover property (zone_trip != 4'h0);
  c_zblk: cover property (zone_blocked != 4'h0);
  c_phs: cover property (phase_start ##1 !phase_start);
  c_bi_sup: cover property (pulse_sup && binary_out);

endmodule
`default_nettype wire

// ---- verification/arc_sensor_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module arc_sensor_model (
  input wire logic sys_clk,
  input wire logic [11:0] point_lit,
  input wire logic [7:0] fitted,
  input wire logic [2:0] units,
  input wire logic bi_level,
  input wire logic pulse_en,
  output logic [3:0] sensor_light,
  output logic [7:0] sensor_detected,
  output logic [2:0] units_detected,
  output logic arc_binary_input
);
  logic [8:0] pulse_cnt = 9'h000;

  // Three sensors per channel.
  // Only fitted sensors can report light, so a lit but missing sensor stays dark.
  always_comb
  begin
    for (int c = 0; c < 4; c++)
    begin
      sensor_light[c] = |(point_lit[3*c +: 3] & ((3'h1 << fitted[2*c +: 2]) - 3'h1));
    end
  end

  // The detected counts are what is really wired up.
  assign sensor_detected = fitted;
  assign units_detected = units;

  // Remote supervision pulses.
  // Remote units pulse the binary input for 20 cycles out of every 400.
  always_ff @(posedge sys_clk)
  begin
    pulse_cnt <= (pulse_cnt == 9'h18f) ? 9'h000 : pulse_cnt + 9'h001;
  end
  assign arc_binary_input = bi_level | (pulse_en & (pulse_cnt < 9'h014));
endmodule
`default_nettype wire

// ---- verification/tb_arc_zone_trip_logic.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_fail++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_arc_zone_trip_logic;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [3:0] sensor_light, light_out, zone_trip, zone_blocked, sensor_fault;
  logic [7:0] sensor_detected;
  logic [2:0] units_detected;
  logic arc_binary_input, binary_out, phase_start, phase_blocked;
  logic residual_start, residual_blocked, io_unit_fault;
  logic sample_tick = 1'b0;
  logic clk_en = 1'b1;
  logic [15:0] pa = 16'h0, pb = 16'h0, pc = 16'h0, ra = 16'h0, rb = 16'h0;
  logic phase_block = 1'b0, residual_block = 1'b0, bi_level = 1'b0, pulse_en = 1'b0;
  logic [3:0] zone_block = 4'h0;
  logic [11:0] point_lit = 12'h0;
  logic [7:0] fitted = 8'h0;
  logic [2:0] units = 3'h0;
  logic [31:0] rd_val;
  logic [15:0] lim;
  int n_fail = 0;
  int checked = 0;
  int seed = 32'h2456;
  int cycles = 0;

  arc_zone_trip_logic u_arc_zone_trip_logic (.sys_clk(sys_clk), .resetn(resetn),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sensor_light(sensor_light),
    .sensor_detected(sensor_detected), .units_detected(units_detected),
    .arc_binary_input(arc_binary_input), .sample_tick(sample_tick),
    .phase_current_a(pa), .phase_current_b(pb), .phase_current_c(pc),
    .residual_input_a(ra), .residual_input_b(rb), .phase_block(phase_block),
    .residual_block(residual_block), .zone_block(zone_block), .light_out(light_out),
    .binary_out(binary_out), .phase_start(phase_start), .phase_blocked(phase_blocked),
    .residual_start(residual_start), .residual_blocked(residual_blocked),
    .zone_trip(zone_trip), .zone_blocked(zone_blocked), .sensor_fault(sensor_fault),
    .io_unit_fault(io_unit_fault));

  arc_sensor_model u_arc_sensor_model (.sys_clk(sys_clk), .point_lit(point_lit),
    .fitted(fitted), .units(units), .bi_level(bi_level), .pulse_en(pulse_en),
    .sensor_light(sensor_light), .sensor_detected(sensor_detected),
    .units_detected(units_detected), .arc_binary_input(arc_binary_input));

  // Free running 10 MHz clock.
  always #50 sys_clk = ~sys_clk;

  // Register write, one strobe cycle.
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Register read; the data stand in the cycle after the strobe.
  task automatic rd(input logic [4:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  // One sample set, the phase value placed on a random phase input.
  task automatic tick(input logic [15:0] p, input logic [15:0] r0, input logic [15:0] r1);
    int k;
    k = $unsigned($random(seed)) % 3;
    @(posedge sys_clk);
    sample_tick <= 1'b1;
    pa <= (k == 0) ? p : 16'h0;
    pb <= (k == 1) ? p : 16'h0;
    pc <= (k == 2) ? p : 16'h0;
    ra <= r0;
    rb <= r1;
    @(posedge sys_clk);
    sample_tick <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  // Lets pin changes pass the input filter.
  task automatic settle;
    repeat (10) @(posedge sys_clk);
    #1;
  endtask

  // Expected zone condition before zone blocking.
  function automatic logic [3:0] zexp(input logic [31:0] c, input logic [15:0] zl,
    input logic [3:0] lt, input logic ph, input logic rs);
    logic [3:0] z;
    for (int i = 0; i < 4; i++)
    begin
      z[i] = c[i] & |(zl[4*i +: 4] & lt) & (!c[4+i] | ph) & (!c[8+i] | rs);
    end
    return z;
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      conclude();
    end
  end

  // Main sequence.
  initial
  begin
    logic [31:0] tmp, ctrl;
    logic [15:0] zl;
    logic [11:0] pl;
    logic [3:0] lt, zv;
    logic pab, rab, phok, rsok;
    int hits;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(arc_zone_pkg::ADDR_CTRL);
    `CHK("ctrl", arc_zone_pkg::CTRL_RST, rd_val); // Zones off.
    rd(arc_zone_pkg::ADDR_PH_LIM);
    `CHK("phase limit", {16'h0, arc_zone_pkg::LIM_RST}, rd_val); // Limit.
    rd(arc_zone_pkg::ADDR_SAMP_REQ);
    `CHK("req", {28'h0, arc_zone_pkg::SAMP_REQ_RST}, rd_val); // Count.
    rd(5'h1c);
    `CHK("unmapped", 32'h0, rd_val); // Reads zero.
    // Sensor and unit counts that differ in one place at a time.
    for (int c = 0; c < 5; c++)
    begin
      tmp = $random(seed);
      fitted <= tmp[7:0];
      units <= tmp[10:8];
      wr(arc_zone_pkg::ADDR_SENS_CFG, (tmp ^ ((c < 4) ? 32'h3 << (2*c) : 32'h100)) & 32'h7ff);
      settle();
      `CHK("sensor fault", (c < 4) ? 4'h1 << c : 4'h0, sensor_fault); // Count.
      `CHK("io fault", c == 4, io_unit_fault); // Units.
    end
    fitted <= 8'hff;
    units <= 3'h5;
    wr(arc_zone_pkg::ADDR_SENS_CFG, 32'h5ff);
    bi_level <= 1'b1;
    settle();
    `CHK("binary", 1'b1, binary_out); // Energized.
    `CHK("faults", 4'h0, sensor_fault); // Three each.
    bi_level <= 1'b0;
    tmp = $random(seed);
    lim = 16'h0100 + 16'(tmp[11:0]);
    wr(arc_zone_pkg::ADDR_PH_LIM, {16'h0, lim});
    wr(arc_zone_pkg::ADDR_RES_LIM, {16'h0, lim});
    // Random zones, lights, currents and blocks; residual input a selected.
    repeat (40)
    begin
      tmp = $random(seed);
      ctrl = {18'h0, 2'h1, tmp[11:0]};
      zl = 16'($random(seed));
      wr(arc_zone_pkg::ADDR_CTRL, ctrl);
      wr(arc_zone_pkg::ADDR_ZLIGHT, {16'h0, zl});
      tmp = $random(seed);
      lt = tmp[3:0];
      for (int c = 0; c < 4; c++)
      begin
        pl[3*c +: 3] = lt[c] ? 3'h1 << (tmp[2*c+4 +: 2] % 3) : 3'h0;
      end
      point_lit <= pl;
      phase_block <= tmp[12];
      residual_block <= tmp[13];
      zone_block <= tmp[17:14];
      pab = tmp[18];
      rab = tmp[19];
      tick(pab ? lim + 16'h1 + 16'(tmp[23:20]) : lim - 16'(tmp[23:20]),
        rab ? lim + 16'h1 : lim, rab ? 16'h0 : 16'hffff);
      phok = pab & !tmp[12];
      rsok = rab & !tmp[13];
      settle();
      zv = zexp(ctrl, zl, lt, phok, rsok);
      `CHK("light", lt, light_out); // Channel light.
      `CHK("ph start", phok, phase_start); // Above limit.
      `CHK("ph blk", pab & tmp[12], phase_blocked); // Blocked.
      `CHK("res start", rsok, residual_start); // Residual.
      `CHK("res blk", rab & tmp[13], residual_blocked); // Blocked.
      `CHK("trip", zv & ~tmp[17:14], zone_trip); // Zone trip.
      `CHK("zone blk", zv & tmp[17:14], zone_blocked); // Zone blocked.
      rd(arc_zone_pkg::ADDR_STATUS);
      `CHK("status", {10'h0, 5'h0, zv & tmp[17:14], zv & ~tmp[17:14], rab & tmp[13],
        pab & tmp[12], rsok, phok, 1'b0, lt}, rd_val); // Levels.
    end
    // Three samples needed, and equal to the limit is not above it.
    phase_block <= 1'b0;
    residual_block <= 1'b0;
    wr(arc_zone_pkg::ADDR_SAMP_REQ, 32'h3);
    // A sample below the limit clears any count left from the random loop.
    tick(16'h0, 16'h0, 16'h0);
    repeat (2) tick(lim + 16'h1, 16'h0, 16'h0);
    `CHK("two samples", 1'b0, phase_start); // Not yet.
    tick(lim + 16'h1, 16'h0, 16'h0);
    `CHK("three samples", 1'b1, phase_start); // Qualified.
    tick(lim, 16'h0, 16'h0);
    `CHK("equal", 1'b0, phase_start); // Strict.
    // A required count of zero acts as one.
    wr(arc_zone_pkg::ADDR_SAMP_REQ, 32'h0);
    // Every residual selection code.
    for (int s = 0; s < 4; s++)
    begin
      wr(arc_zone_pkg::ADDR_CTRL, 32'(s) << 12);
      tick(16'h0, lim + 16'h1, 16'h0);
      `CHK("sel a", s == 1, residual_start); // Input a.
      tick(16'h0, 16'h0, lim + 16'h1);
      `CHK("sel b", s == 2, residual_start); // Input b.
    end
    // Supervision pulses are masked; a held input still gets through.
    wr(arc_zone_pkg::ADDR_CTRL, 32'h4000);
    pulse_en <= 1'b1;
    hits = 0;
    repeat (1200)
    begin
      @(posedge sys_clk);
      #1;
      if (binary_out !== 1'b0)
      begin
        hits++;
      end
    end
    `CHK("pulses seen", 0, hits); // Masked.
    pulse_en <= 1'b0;
    bi_level <= 1'b1;
    repeat (2020) @(posedge sys_clk);
    settle();
    `CHK("held input", 1'b1, binary_out); // Long input.
    // A low clock enable freezes every output.
    clk_en <= 1'b0;
    bi_level <= 1'b0;
    settle();
    `CHK("frozen", 1'b1, binary_out); // Held.
    clk_en <= 1'b1;
    bi_level <= 1'b1;
    // A reset in mid-run clears the outputs and the settings.
    resetn <= 1'b0;
    #1;
    `CHK("reset bi", 1'b0, binary_out); // Cleared.
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    settle();
    `CHK("bi after reset", 1'b1, binary_out); // Unmasked.
    `CHK("faults after reset", 4'hf, sensor_fault); // Count zero.
    `CHK("units after reset", 1'b1, io_unit_fault); // Units zero.
    bi_level <= 1'b0;
    settle();
    `CHK("released", 1'b0, binary_out); // Drops.
    conclude();
  end
endmodule
`default_nettype wire
